/* core/boot_pkg.sv */
// Constants and types for the primary boot sequencer
// ---------------------------------------------------------------
// Summary of operation
// R01 - Host boot: port setup from config pins
// R02 - Host checks page 0 range/offset registers
// R03 - Host checks semaphore zero, tests offset 0x44
// R04 - Host loads secondary loader, max 64KB
// R05 - Semaphore key remaps RAM, runs at 0x44
// R06 - SPI master, 8 bit, MSB first, mode 0
// R07 - 1 MBit/s, select on general line 31
// R08 - Probe 0xE8 then 0x03 for ID 0x5A
// R09 - No ID: enable watchdog, reset on expiry
// R10 - Address bytes from identifier position
// R11 - Word count high then low, then data
// R12 - Copy image in order, RAM bounded
// R13 - Done: remap user RAM, branch to 0x44
// R14 - Exit leaves 251 ms watchdog running
// R15 - Exit stack 0x0800_FD00, TCM map fixed
// R16 - Exit: MMU off, SDRAM raw, shift mode 1
// R17 - Reset mirrors boot ROM at zero
// R18 - Swap selection maps segment zero target
// R19 - Reserved swap code: segment zero times out
// R20 - Boot pins latched at reset release
// R21 - Four bytes per word, ascending addresses
// ---------------------------------------------------------------
package boot_pkg;
  // Clocks and timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int WDT_PERIOD_MS  = 251;
  localparam int WDT_CYC        = WDT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int SPI_RATE_BPS   = 1_000_000;
  localparam int LINK_PERIOD_PS = 12_000;
  localparam int SPI_HALF_NS    = 1_000_000_000 / (2 * SPI_RATE_BPS);
  localparam int SPI_HALF_CYC   = (SPI_HALF_NS * 1000) / LINK_PERIOD_PS;
  localparam int CS_GAP_NS      = 1000;
  localparam int CS_GAP_CYC     = (CS_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STRAP_DELAY    = 3;
  // Host windows
  localparam logic [31:0] PAGE0_RANGE   = 32'h0010_0000;
  localparam logic [31:0] PAGE0_OFFSET  = 32'h0800_0000;
  localparam logic [7:0]  REG_RANGE0    = 8'h00;
  localparam logic [7:0]  REG_OFFSET0   = 8'h04;
  localparam logic [15:0] SEMA_OFS      = 16'h0040;
  localparam logic [31:0] SEMA_KEY      = 32'h6879_9786;
  // Exit state
  localparam logic [31:0] ENTRY_OFS     = 32'h0000_0044;
  localparam logic [31:0] STACK_TOP     = 32'h0800_FD00;
  localparam logic [31:0] DTCM_BASE     = 32'h0800_0000;
  localparam logic [7:0]  ITCM_KB       = 8'h40;
  localparam logic [7:0]  DTCM_KB       = 8'hC0;
  // Serial flash
  localparam logic [7:0]  CMD_FAST      = 8'hE8;
  localparam logic [7:0]  CMD_READ      = 8'h03;
  localparam logic [7:0]  BOOT_ID       = 8'h5A;
  localparam logic [7:0]  PAD_BYTE      = 8'h00;
  localparam logic [3:0]  PROBE_LEN     = 4'hA;
  // Boot pins and config pins
  localparam logic [3:0]  BOOT_HOST     = 4'h1;
  localparam logic [3:0]  BOOT_SPI      = 4'h2;
  localparam int          CFG_WIDTH_BIT = 0;
  localparam int          CFG_POL_BIT   = 1;
  localparam int          CFG_MODE_LSB  = 2;
  // Segment zero swap codes, codes above ITCM are reserved
  localparam logic [2:0]  SWAP_ROM      = 3'h0;
  localparam logic [2:0]  SWAP_SDRAM    = 3'h1;
  localparam logic [2:0]  SWAP_BANK0    = 3'h2;
  localparam logic [2:0]  SWAP_ITCM     = 3'h3;

  typedef enum logic [9:0] {
    ST_INIT  = 10'h001,
    ST_HOST  = 10'h002,
    ST_CMD   = 10'h004,
    ST_PROBE = 10'h008,
    ST_GAP   = 10'h010,
    ST_CNTH  = 10'h020,
    ST_CNTL  = 10'h040,
    ST_DATA  = 10'h080,
    ST_FAIL  = 10'h100,
    ST_EXIT  = 10'h200
  } boot_state_t;

  typedef enum logic [2:0] {
    LS_IDLE = 3'h1,
    LS_LOW  = 3'h2,
    LS_HIGH = 3'h4
  } link_state_t;
endpackage : boot_pkg

/* core/spi_link.sv */
// Serial byte engine running on the link clock
`timescale 1ns/1ps
`default_nettype none
module spi_link
  import boot_pkg::*;
#(
  parameter int HALF_CYC = SPI_HALF_CYC
) (
  // Link clock and reset
  input  wire logic       link_clk_i,
  input  wire logic       arst_n_i,
  // Request from system domain
  input  wire logic       req_tgl_i,
  input  wire logic [7:0] tx_i,
  output logic            ack_tgl_o,
  output logic [7:0]      rx_o,
  // Serial pins
  output logic            sck_o,
  output logic            mosi_o,
  input  wire logic       miso_i
);
  link_state_t st_r;
  logic        req_s1;
  logic        req_s2;
  logic        req_seen_r;
  logic        miso_s1;
  logic        miso_s2;
  logic [7:0]  sh_r;
  logic [7:0]  rsh_r;
  logic [2:0]  bit_r;
  logic [15:0] div_r;
  logic        tick;

  assign tick = (div_r == 16'(HALF_CYC - 1));

  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      req_s1  <= req_tgl_i;
      req_s2  <= req_s1;
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
    end
  end

  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= 16'h0000;
    end else if (st_r == LS_IDLE || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // R06 mode 0 shifter
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r       <= LS_IDLE;
      req_seen_r <= 1'b0;
      ack_tgl_o  <= 1'b0;
      rx_o       <= 8'h00;
      sh_r       <= 8'h00;
      rsh_r      <= 8'h00;
      bit_r      <= 3'h0;
      sck_o      <= 1'b0;
      mosi_o     <= 1'b0;
    end else begin
      case (st_r)
        LS_IDLE: begin
          if (req_s2 != req_seen_r) begin
            req_seen_r <= req_s2;
            sh_r       <= tx_i;
            mosi_o     <= tx_i[7];
            bit_r      <= 3'h0;
            st_r       <= LS_LOW;
          end
        end
        LS_LOW: begin
          if (tick) begin
            sck_o <= 1'b1;
            rsh_r <= {rsh_r[6:0], miso_s2};
            st_r  <= LS_HIGH;
          end
        end
        LS_HIGH: begin
          if (tick) begin
            sck_o <= 1'b0;
            if (bit_r == 3'h7) begin
              rx_o      <= rsh_r;
              ack_tgl_o <= ~ack_tgl_o;
              st_r      <= LS_IDLE;
            end else begin
              sh_r   <= {sh_r[6:0], 1'b0};
              mosi_o <= sh_r[6];
              bit_r  <= bit_r + 3'h1;
              st_r   <= LS_LOW;
            end
          end
        end
        default: st_r <= LS_IDLE;
      endcase
    end
  end
endmodule : spi_link
`default_nettype wire

/* core/boot_seq.sv */
// Primary boot sequencer: host boot, serial boot and segment swap
`timescale 1ns/1ps
`default_nettype none
module boot_seq
  import boot_pkg::*;
#(
  parameter int RAM_WORDS = 16384,
  parameter int WDT_CYCLES = WDT_CYC,
  parameter int HALF_CYC  = SPI_HALF_CYC
) (
  // Clocks and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        link_clk_i,
  // Straps
  input  wire logic [3:0]  boot_pins_i,
  input  wire logic [3:0]  config_pins_i,
  // Host port setup
  output logic             host_data_width_o,
  output logic             host_ready_polarity_o,
  output logic [1:0]       host_access_mode_o,
  output logic             host_register_window_select_o,
  output logic             host_memory_window_select_o,
  // Host register window
  input  wire logic        host_reg_rd_i,
  input  wire logic [7:0]  host_reg_addr_i,
  output logic [31:0]      host_reg_rdata_o,
  // Host memory window
  input  wire logic        host_mem_wr_i,
  input  wire logic        host_mem_rd_i,
  input  wire logic [15:0] host_mem_addr_i,
  input  wire logic [31:0] host_mem_wdata_i,
  output logic [31:0]      host_mem_rdata_o,
  // Serial flash
  output logic             spi_sck_o,
  output logic             spi_mosi_o,
  input  wire logic        spi_miso_i,
  output logic             flash_select_line_o,
  // Watchdog
  input  wire logic        wdt_kick_i,
  output logic             wdt_running_o,
  output logic             wdt_reset_o,
  // Segment zero
  input  wire logic        swap_wr_i,
  input  wire logic [2:0]  swap_sel_i,
  input  wire logic        seg0_access_i,
  output logic [2:0]       swap_o,
  output logic             seg0_rom_o,
  output logic             seg0_sdram_o,
  output logic             seg0_bank0_o,
  output logic             seg0_itcm_o,
  output logic             access_timeout_o,
  output logic             rom_orig_en_o,
  // Exit state
  output logic             boot_done_o,
  output logic             boot_failed_o,
  output logic [31:0]      entry_pc_o,
  output logic [31:0]      stack_ptr_o,
  output logic [31:0]      dtcm_base_o,
  output logic [7:0]       itcm_size_kb_o,
  output logic [7:0]       dtcm_size_kb_o,
  output logic             mmu_en_o,
  output logic             sdram_init_o,
  output logic             external_memory_shift_mode_o,
  // Serial boot status
  output logic [7:0]       read_cmd_o,
  output logic [3:0]       addr_bytes_o,
  output logic [15:0]      word_count_o
);
  localparam int AW = $clog2(RAM_WORDS);

  boot_state_t st_r;
  logic [31:0] ram_r [RAM_WORDS];
  logic [3:0]  bp_s1;
  logic [3:0]  bp_s2;
  logic [3:0]  cf_s1;
  logic [3:0]  cf_s2;
  logic [3:0]  strap_r;
  logic [3:0]  cfg_r;
  logic [1:0]  init_r;
  logic [31:0] sema_r;
  logic        req_tgl_r;
  logic        pend_r;
  logic        ack_s1;
  logic        ack_s2;
  logic        ack_tgl;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_r;
  logic        retry_r;
  logic [3:0]  cnt_r;
  logic [15:0] gap_r;
  logic [1:0]  lane_r;
  logic [23:0] wbuf_r;
  logic [15:0] widx_r;
  logic        wdt_en_r;
  logic [31:0] wdt_r;
  logic        done_w;
  logic        link_st;
  logic        win_wr;
  logic        sema_hit;
  logic        spi_wr;
  logic [15:0] words;
  logic        swap_rsvd;

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bp_s1 <= 4'h0;
      bp_s2 <= 4'h0;
      cf_s1 <= 4'h0;
      cf_s2 <= 4'h0;
    end else begin
      bp_s1 <= boot_pins_i;
      bp_s2 <= bp_s1;
      cf_s1 <= config_pins_i;
      cf_s2 <= cf_s1;
    end
  end

  // R20 latch pins over the first three cycles after release, then hold
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_r  <= 2'h0;
      strap_r <= 4'h0;
      cfg_r   <= 4'h0;
    end else if (init_r != 2'(STRAP_DELAY)) begin
      init_r  <= init_r + 2'h1;
      strap_r <= bp_s2;
      cfg_r   <= cf_s2;
    end
  end

  // ---------------------------------------------------------------
  // Host windows
  // ---------------------------------------------------------------
  // R01 port setup from config
  assign host_data_width_o     = cfg_r[CFG_WIDTH_BIT];
  assign host_ready_polarity_o = cfg_r[CFG_POL_BIT];
  assign host_access_mode_o    = cfg_r[CFG_MODE_LSB +: 2];

  assign sema_hit = (host_mem_addr_i[15:2] == SEMA_OFS[15:2]);
  assign win_wr   = host_mem_wr_i && host_memory_window_select_o;
  assign link_st  = (st_r == ST_CMD) || (st_r == ST_PROBE) ||
                    (st_r == ST_CNTH) || (st_r == ST_CNTL) ||
                    (st_r == ST_DATA);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_register_window_select_o <= 1'b0;
      host_memory_window_select_o   <= 1'b0;
    end else if (st_r == ST_HOST) begin
      // R01 windows onto boot RAM
      host_register_window_select_o <= 1'b1;
      host_memory_window_select_o   <= 1'b1;
    end else if (st_r == ST_EXIT) begin
      host_memory_window_select_o   <= 1'b0;
    end
  end

  // R02 page 0 map read back
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_reg_rdata_o <= 32'h0000_0000;
    end else if (host_reg_rd_i) begin
      if (host_reg_addr_i == REG_RANGE0) begin
        host_reg_rdata_o <= PAGE0_RANGE;
      end else if (host_reg_addr_i == REG_OFFSET0) begin
        host_reg_rdata_o <= PAGE0_OFFSET;
      end else begin
        host_reg_rdata_o <= 32'h0000_0000;
      end
    end
  end

  // R03 semaphore starts at zero
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sema_r <= 32'h0000_0000;
    end else if (win_wr && sema_hit) begin
      sema_r <= host_mem_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_mem_rdata_o <= 32'h0000_0000;
    end else if (host_mem_rd_i) begin
      if (sema_hit) begin
        host_mem_rdata_o <= sema_r;
      end else begin
        host_mem_rdata_o <= ram_r[host_mem_addr_i[AW+1:2]];
      end
    end
  end

  // ---------------------------------------------------------------
  // Boot RAM
  // ---------------------------------------------------------------
  // R12 serial writes bounded by RAM size
  assign spi_wr = (st_r == ST_DATA) && done_w && (lane_r == 2'h3) &&
                  (widx_r < 16'(RAM_WORDS));

  always_ff @(posedge clock_i) begin
    if (spi_wr) begin
      // R21 first byte lowest address
      ram_r[widx_r[AW-1:0]] <= {rx_byte, wbuf_r};
    end else if (win_wr && !sema_hit) begin
      ram_r[host_mem_addr_i[AW+1:2]] <= host_mem_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // Link crossing
  // ---------------------------------------------------------------
  // Data words stay stable while the toggle is in flight
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  assign done_w = pend_r && (ack_s2 == req_tgl_r);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_tgl_r <= 1'b0;
      pend_r    <= 1'b0;
      tx_r      <= 8'h00;
    end else if (link_st && !pend_r) begin
      req_tgl_r <= ~req_tgl_r;
      pend_r    <= 1'b1;
      // R08 command then zero address
      tx_r      <= (st_r == ST_CMD) ? read_cmd_o : PAD_BYTE;
    end else if (done_w) begin
      pend_r    <= 1'b0;
    end
  end

  spi_link #(
    .HALF_CYC (HALF_CYC)
  ) u_link (
    .link_clk_i (link_clk_i),
    .arst_n_i   (arst_n_i),
    .req_tgl_i  (req_tgl_r),
    .tx_i       (tx_r),
    .ack_tgl_o  (ack_tgl),
    .rx_o       (rx_byte),
    .sck_o      (spi_sck_o),
    .mosi_o     (spi_mosi_o),
    .miso_i     (spi_miso_i)
  );

  // R07 select on general line, low active
  assign flash_select_line_o = !link_st;

  // ---------------------------------------------------------------
  // Boot sequence
  // ---------------------------------------------------------------
  assign words = {word_count_o[15:8], rx_byte};

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r         <= ST_INIT;
      read_cmd_o   <= CMD_FAST;
      retry_r      <= 1'b0;
      cnt_r        <= 4'h0;
      gap_r        <= 16'h0000;
      addr_bytes_o <= 4'h0;
      word_count_o <= 16'h0000;
      lane_r       <= 2'h0;
      wbuf_r       <= 24'h00_0000;
      widx_r       <= 16'h0000;
    end else begin
      case (st_r)
        ST_INIT: begin
          if (init_r == 2'(STRAP_DELAY)) begin
            if (strap_r == BOOT_HOST) begin
              st_r <= ST_HOST;
            end else if (strap_r == BOOT_SPI) begin
              st_r <= ST_CMD;
            end
          end
        end
        ST_HOST: begin
          // R05 key releases the device
          if (sema_r == SEMA_KEY) begin
            st_r <= ST_EXIT;
          end
        end
        ST_CMD: begin
          if (done_w) begin
            cnt_r <= 4'h0;
            st_r  <= ST_PROBE;
          end
        end
        ST_PROBE: begin
          if (done_w) begin
            cnt_r <= cnt_r + 4'h1;
            // R08 search for identifier
            if (rx_byte == BOOT_ID) begin
              // R10 address bytes seen before it
              addr_bytes_o <= cnt_r;
              st_r         <= ST_CNTH;
            end else if (cnt_r == PROBE_LEN - 4'h1) begin
              gap_r <= 16'h0000;
              st_r  <= retry_r ? ST_FAIL : ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // Select stays high a while between probes
          gap_r <= gap_r + 16'h0001;
          if (gap_r == 16'(CS_GAP_CYC)) begin
            retry_r    <= 1'b1;
            read_cmd_o <= CMD_READ;
            st_r       <= ST_CMD;
          end
        end
        ST_CNTH: begin
          // R11 count, high byte first
          if (done_w) begin
            word_count_o[15:8] <= rx_byte;
            st_r               <= ST_CNTL;
          end
        end
        ST_CNTL: begin
          if (done_w) begin
            word_count_o[7:0] <= rx_byte;
            lane_r            <= 2'h0;
            widx_r            <= 16'h0000;
            st_r              <= (words == 16'h0000) ? ST_EXIT : ST_DATA;
          end
        end
        ST_DATA: begin
          // R12 bytes in arrival order
          if (done_w) begin
            lane_r <= lane_r + 2'h1;
            wbuf_r <= {rx_byte, wbuf_r[23:8]};
            if (lane_r == 2'h3) begin
              widx_r <= widx_r + 16'h0001;
              if (widx_r + 16'h0001 == word_count_o) begin
                st_r <= ST_EXIT;
              end
            end
          end
        end
        ST_FAIL: st_r <= ST_FAIL;
        ST_EXIT: st_r <= ST_EXIT;
        default: st_r <= ST_INIT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  // R09 failure arms the watchdog
  // R14 exit leaves it running
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_en_r    <= 1'b0;
      wdt_r       <= 32'h0000_0000;
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= 1'b0;
      if (st_r == ST_FAIL || st_r == ST_EXIT) begin
        wdt_en_r <= 1'b1;
      end
      if (!wdt_en_r || wdt_kick_i) begin
        wdt_r <= 32'h0000_0000;
      end else if (wdt_r == 32'(WDT_CYCLES - 1)) begin
        // Expiry pulses the reset request for one cycle and restarts the count
        wdt_r       <= 32'h0000_0000;
        wdt_reset_o <= 1'b1;
      end else begin
        wdt_r <= wdt_r + 32'h0000_0001;
      end
    end
  end

  assign wdt_running_o = wdt_en_r;

  // ---------------------------------------------------------------
  // Exit state and segment zero
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // R17 boot ROM mirrored at zero
      swap_o                       <= SWAP_ROM;
      boot_done_o                  <= 1'b0;
      boot_failed_o                <= 1'b0;
      entry_pc_o                   <= 32'h0000_0000;
      stack_ptr_o                  <= 32'h0000_0000;
      dtcm_base_o                  <= 32'h0000_0000;
      itcm_size_kb_o               <= 8'h00;
      dtcm_size_kb_o               <= 8'h00;
      mmu_en_o                     <= 1'b0;
      sdram_init_o                 <= 1'b0;
      external_memory_shift_mode_o <= 1'b0;
    end else if (st_r == ST_EXIT && !boot_done_o) begin
      // R05 host image runs at 0x44
      // R13 RAM becomes code at zero
      swap_o                       <= SWAP_ITCM;
      boot_done_o                  <= 1'b1;
      entry_pc_o                   <= ENTRY_OFS;
      // R15 stack and TCM map
      stack_ptr_o                  <= STACK_TOP;
      dtcm_base_o                  <= DTCM_BASE;
      itcm_size_kb_o               <= ITCM_KB;
      dtcm_size_kb_o               <= DTCM_KB;
      // R16 no MMU, no SDRAM setup
      mmu_en_o                     <= 1'b0;
      sdram_init_o                 <= 1'b0;
      external_memory_shift_mode_o <= 1'b1;
    end else begin
      boot_failed_o <= boot_failed_o | (st_r == ST_FAIL);
      if (swap_wr_i && boot_done_o) begin
        swap_o <= swap_sel_i;
      end
    end
  end

  // R18 segment zero target decode
  // R19 reserved code decodes nothing
  assign swap_rsvd        = (swap_o > SWAP_ITCM);
  assign seg0_rom_o       = seg0_access_i && (swap_o == SWAP_ROM);
  assign seg0_sdram_o     = seg0_access_i && (swap_o == SWAP_SDRAM);
  assign seg0_bank0_o     = seg0_access_i && (swap_o == SWAP_BANK0);
  assign seg0_itcm_o      = seg0_access_i && (swap_o == SWAP_ITCM);
  assign access_timeout_o = seg0_access_i && swap_rsvd;
  // R17 original ROM range always decoded
  assign rom_orig_en_o    = 1'b1;
endmodule : boot_seq
`default_nettype wire

/* dv/boot_seq_properties.sv */
// Port-level checks of the boot sequencer
`timescale 1ns/1ps
`default_nettype none
module boot_seq_properties
  import boot_pkg::*;
(
  // Watched ports
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  input wire logic        host_reg_rd_i,
  input wire logic [7:0]  host_reg_addr_i,
  input wire logic [31:0] host_reg_rdata_o,
  input wire logic        host_mem_wr_i,
  input wire logic [15:0] host_mem_addr_i,
  input wire logic [31:0] host_mem_wdata_i,
  input wire logic        host_memory_window_select_o,
  input wire logic        spi_sck_o,
  input wire logic        flash_select_line_o,
  input wire logic        seg0_access_i,
  input wire logic [2:0]  swap_o,
  input wire logic        seg0_rom_o,
  input wire logic        access_timeout_o,
  input wire logic        boot_done_o,
  input wire logic        wdt_running_o,
  input wire logic [31:0] entry_pc_o,
  input wire logic        mmu_en_o,
  input wire logic        external_memory_shift_mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  reg_range_a: assert property (
    host_reg_rd_i && host_reg_addr_i == REG_RANGE0 |=> host_reg_rdata_o == PAGE0_RANGE)
    else $error("range read wrong");
  reg_offset_a: assert property (
    host_reg_rd_i && host_reg_addr_i == REG_OFFSET0 |=> host_reg_rdata_o == PAGE0_OFFSET)
    else $error("offset read wrong");
  key_exit_a: assert property (
    host_mem_wr_i && host_mem_addr_i == SEMA_OFS && host_mem_wdata_i == SEMA_KEY
    && host_memory_window_select_o && !boot_done_o |-> ##[1:4] boot_done_o)
    else $error("key did not end boot");
  exit_state_a: assert property (
    $rose(boot_done_o) |-> entry_pc_o == ENTRY_OFS && swap_o == SWAP_ITCM && wdt_running_o)
    else $error("exit state wrong");
  exit_config_a: assert property (
    boot_done_o |-> !mmu_en_o && external_memory_shift_mode_o)
    else $error("exit config wrong");
  // Sampled on the system clock, so only the idle level is judged here
  sck_idle_a: assert property (
    flash_select_line_o |-> !spi_sck_o)
    else $error("serial clock not idle");
  seg_timeout_a: assert property (
    seg0_access_i && swap_o[2] |-> access_timeout_o && !seg0_rom_o)
    else $error("reserved swap decoded");
  rom_mirror_a: assert property (
    seg0_access_i && swap_o == SWAP_ROM |-> seg0_rom_o && !access_timeout_o)
    else $error("boot rom not mirrored");
  cover property ($rose(boot_done_o));
  cover property ($rose(access_timeout_o));
  cover property ($fell(flash_select_line_o));
endmodule : boot_seq_properties
`default_nettype wire

/* dv/spi_flash_model.sv */
// Serial flash model answering the boot probe
`timescale 1ns/1ps
`default_nettype none
module spi_flash_model (
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic sel_n_i,
  output logic      miso_o
);
  // Answers only the plain read, so the fast probe must fail first
  logic [7:0] rsp [14] = '{8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'h00, 8'h02, 8'h11, 8'h22,
                          8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
  logic [7:0] cmd = 8'h00;
  logic       b   = 1'b1;
  int         n   = 0;
  always @(negedge sel_n_i) begin
    n = 0;
    b = 1'b1;
  end
  always @(posedge sck_i) begin
    if (!sel_n_i && n < 8) cmd = {cmd[6:0], mosi_i};
  end
  always @(negedge sck_i) begin
    if (!sel_n_i) begin
      n = n + 1;
      b = (n < 8 || n >= 120 || cmd != 8'h03) ? 1'b1 : rsp[n/8-1][7-n%8];
    end
  end
  assign miso_o = sel_n_i ? ~b : b;
endmodule : spi_flash_model
`default_nettype wire

/* dv/tb_boot_seq.sv */
// Self-checking bench for the boot sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_boot_seq;
  import boot_pkg::*;
  typedef struct {logic [1:0] k; logic [15:0] a; logic [31:0] d;} row_t;
  // Kind 0 writes memory, 1 reads memory, 2 reads a register
  row_t rows [6] = '{'{2'h2, 16'h0000, PAGE0_RANGE}, '{2'h2, 16'h0004, PAGE0_OFFSET},
    '{2'h2, 16'h0008, 32'h0}, '{2'h1, 16'h0040, 32'h0},
    '{2'h0, 16'h0044, 32'hA5C3_0F96}, '{2'h1, 16'h0044, 32'hA5C3_0F96}};
  logic        clock_i = 1'b0, link_clk_i = 1'b0, arst_n_i = 1'b0;
  logic [3:0]  boot_pins_i = 4'h1;
  logic        host_reg_rd_i = 1'b0, host_mem_wr_i = 1'b0, host_mem_rd_i = 1'b0;
  logic [7:0]  host_reg_addr_i = 8'h00;
  logic [15:0] host_mem_addr_i = 16'h0000;
  logic [31:0] host_mem_wdata_i = 32'h0;
  logic        swap_wr_i = 1'b0, spi_miso_i, spi_sck_o, spi_mosi_o, flash_select_line_o;
  logic [2:0]  swap_sel_i = 3'h0, swap_o;
  logic [31:0] host_reg_rdata_o, host_mem_rdata_o;
  logic        host_data_width_o, host_ready_polarity_o, access_timeout_o, boot_done_o;
  logic [1:0]  host_access_mode_o;
  logic [7:0]  read_cmd_o;
  logic [3:0]  addr_bytes_o;
  logic [15:0] word_count_o;
  int          miscompares = 0, total_checks = 0;
  boot_seq #(.WDT_CYCLES(200), .HALF_CYC(4)) boot_seq_i (.*, .config_pins_i(4'hB),
    .host_register_window_select_o(), .host_memory_window_select_o(), .wdt_kick_i(1'b0),
    .wdt_running_o(), .wdt_reset_o(), .seg0_access_i(1'b1), .seg0_rom_o(),
    .seg0_sdram_o(), .seg0_bank0_o(), .seg0_itcm_o(), .rom_orig_en_o(), .boot_failed_o(),
    .entry_pc_o(), .stack_ptr_o(), .dtcm_base_o(), .itcm_size_kb_o(), .dtcm_size_kb_o(),
    .mmu_en_o(), .sdram_init_o(), .external_memory_shift_mode_o());
  spi_flash_model spi_flash_model_i (.sck_i(spi_sck_o), .mosi_i(spi_mosi_o),
    .sel_n_i(flash_select_line_o), .miso_o(spi_miso_i));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // Offset start, unrelated phase
  initial begin
    #2.5;
    forever #6 link_clk_i = ~link_clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  task automatic hacc(input logic [1:0] k, input logic [15:0] a, input logic [31:0] d);
    host_mem_wr_i <= (k == 2'h0);
    host_mem_rd_i <= (k == 2'h1);
    host_reg_rd_i <= (k == 2'h2);
    host_mem_addr_i <= a;
    host_reg_addr_i <= a[7:0];
    host_mem_wdata_i <= d;
    @(posedge clock_i);
    {host_mem_wr_i, host_mem_rd_i, host_reg_rd_i} <= 3'h0;
    repeat (2) @(posedge clock_i);
  endtask : hacc
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    check({host_access_mode_o, host_ready_polarity_o, host_data_width_o}, 32'hB);
    foreach (rows[i]) begin
      hacc(rows[i].k, rows[i].a, rows[i].d);
      if (rows[i].k == 2'h2) check(host_reg_rdata_o, rows[i].d);
      if (rows[i].k == 2'h1) check(host_mem_rdata_o, rows[i].d);
    end
    hacc(2'h0, SEMA_OFS, SEMA_KEY);
    repeat (3) @(posedge clock_i);
    check({boot_done_o, swap_o}, {1'b1, SWAP_ITCM});
    swap_sel_i <= 3'h7;
    swap_wr_i <= 1'b1;
    @(posedge clock_i);
    swap_wr_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check(access_timeout_o, 1'b1);
    $display("host boot test done");
    arst_n_i <= 1'b0;
    boot_pins_i <= 4'h2;
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (20000) if (boot_done_o !== 1'b1) @(posedge clock_i);
    check({read_cmd_o, addr_bytes_o, word_count_o}, {CMD_READ, 4'h3, 16'h0002});
    hacc(2'h1, 16'h0000, 32'h0);
    check(host_mem_rdata_o, 32'h4433_2211);
    hacc(2'h1, 16'h0004, 32'h0);
    check(host_mem_rdata_o, 32'h8877_6655);
    $display("serial boot test done");
    report_and_stop();
  end
  initial begin
    #400us;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_boot_seq
bind boot_seq boot_seq_properties boot_seq_properties_i (.*);
`default_nettype wire
